// ===== hw/hbhd_pkg.sv
// Shared constants for the host bus handshake and decode block
package hbhd_pkg;
	// ****************************************
	// Widths and timing
	// ****************************************
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DEC_HI = 15; // Top address bit compared
	localparam int unsigned DEC_LO = 4; // Lowest address bit compared
	localparam int unsigned DEC_W = DEC_HI - DEC_LO + 1;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned LCLK_MIN_PERIOD_NS = 20; // 50 MHz ceiling on the link clock
	// Run slower than the ceiling so each bus clock level spans enough core
	// clocks for the device's three-stage pin filter to see it settle
	localparam int unsigned LCLK_PERIOD_NS = 80;
	localparam int unsigned LCLK_DIV = LCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int unsigned WAIT_W = 4;
	localparam logic [3:0] DEF_WAIT = 4'h0002;
	localparam logic [DEC_W-1:0] BASE_RST = 12'h0030;
	// ****************************************
	// Device cycle states
	// ****************************************
	typedef enum logic [1:0] {
		HBHD_IDLE = 2'b00,
		HBHD_WAIT = 2'b01,
		HBHD_RDY = 2'b10,
		HBHD_HOLD = 2'b11
	} hbhd_state_t;
endpackage : hbhd_pkg

// ===== hw/hbhd_if.sv
// Pin bundle between the host bus master and the device port
`timescale 1ns/10ps
interface hbhd_if;
	logic bclk;
	logic [hbhd_pkg::ADDR_W-1:0] addr;
	logic address_enable_in;
	logic data_path_select_n;
	logic read_strobe_n;
	logic cycle_marker_n;
	logic ready_return_n;
	logic bus_mode_strap_n;
	logic cyc_start;
	logic sync_ready_n;
	logic async_ready_out;
	logic local_device_hit_n;
	logic interrupt_out_n;
	logic power_event_n;
	modport dev (
		input bclk, addr, address_enable_in, data_path_select_n, read_strobe_n,
		input cycle_marker_n, ready_return_n, bus_mode_strap_n, cyc_start,
		output sync_ready_n, async_ready_out, local_device_hit_n,
		output interrupt_out_n, power_event_n
	);
	modport host (
		output bclk, addr, address_enable_in, data_path_select_n, read_strobe_n,
		output cycle_marker_n, ready_return_n, bus_mode_strap_n, cyc_start,
		input sync_ready_n, async_ready_out, local_device_hit_n,
		input interrupt_out_n, power_event_n
	);
endinterface : hbhd_if

// ===== hw/hbhd_dev.sv
// Device end: ready handshakes, local device decode, event outputs
`timescale 1ns/10ps
module hbhd_dev (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	hbhd_if.dev bus,
	input wire logic [hbhd_pkg::DEC_W-1:0] base_addr_i,
	input wire logic [hbhd_pkg::WAIT_W-1:0] wait_cycles_i,
	input wire logic irq_status_any_i,
	input wire logic wake_event_i,
	output logic queue_access_o,
	output logic sync_mode_o,
	output logic cycle_done_o
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Three stages; a change counts when stages two and three agree
	logic [2:0] bclk_sync_ff, start_sync_ff, strap_sync_ff, rtn_sync_ff;
	logic bclk_lvl_ff, start_lvl_ff, strap_lvl_ff, rtn_lvl_ff;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			bclk_sync_ff <= 3'h0;
			start_sync_ff <= 3'h0;
			strap_sync_ff <= 3'h0;
			rtn_sync_ff <= 3'h7;
		end else begin
			bclk_sync_ff <= {bclk_sync_ff[1:0], bus.bclk};
			start_sync_ff <= {start_sync_ff[1:0], bus.cyc_start};
			strap_sync_ff <= {strap_sync_ff[1:0], bus.bus_mode_strap_n};
			rtn_sync_ff <= {rtn_sync_ff[1:0], bus.ready_return_n};
		end
	end
	// Filtered levels follow only when stages two and three agree
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			bclk_lvl_ff <= 1'b0;
			start_lvl_ff <= 1'b0;
			strap_lvl_ff <= 1'b0;
			rtn_lvl_ff <= 1'b1;
		end else begin
			if (bclk_sync_ff[1] == bclk_sync_ff[2]) bclk_lvl_ff <= bclk_sync_ff[2];
			if (start_sync_ff[1] == start_sync_ff[2]) start_lvl_ff <= start_sync_ff[2];
			if (strap_sync_ff[1] == strap_sync_ff[2]) strap_lvl_ff <= strap_sync_ff[2];
			if (rtn_sync_ff[1] == rtn_sync_ff[2]) rtn_lvl_ff <= rtn_sync_ff[2];
		end
	end
	// ****************************************
	// Mode and edges
	// ****************************************
	logic bclk_prev_ff, start_prev_ff, mode_sync_ff;
	logic bclk_rise, start_rise;
	assign bclk_rise = bclk_lvl_ff & ~bclk_prev_ff;
	assign start_rise = start_lvl_ff & ~start_prev_ff;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			bclk_prev_ff <= 1'b0;
			start_prev_ff <= 1'b0;
		end else begin
			bclk_prev_ff <= bclk_lvl_ff;
			start_prev_ff <= start_lvl_ff;
		end
	end
	// Strap re-read every cycle; low or floating means synchronous
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) mode_sync_ff <= 1'b1;
		else mode_sync_ff <= ~strap_lvl_ff;
	end
	assign sync_mode_o = mode_sync_ff;
	// ****************************************
	// Access cycle state machine
	// ****************************************
	// Sync mode steps wait and ready on rising bus clock edges only; async counts core clocks
	hbhd_pkg::hbhd_state_t state_ff, nxt_state;
	logic [hbhd_pkg::WAIT_W-1:0] wait_ff, nxt_wait;
	logic step;
	assign step = mode_sync_ff ? bclk_rise : 1'b1;
	always_comb begin
		nxt_state = state_ff;
		nxt_wait = wait_ff;
		case (state_ff)
			hbhd_pkg::HBHD_IDLE: begin
				if (start_rise) begin
					nxt_state = hbhd_pkg::HBHD_WAIT;
					nxt_wait = (wait_cycles_i == '0) ? hbhd_pkg::DEF_WAIT : wait_cycles_i;
				end
			end
			hbhd_pkg::HBHD_WAIT: begin
				if (step) begin
					if (wait_ff <= 4'h0001) nxt_state = hbhd_pkg::HBHD_RDY;
					else nxt_wait = wait_ff - 4'h0001;
				end
			end
			hbhd_pkg::HBHD_RDY: begin
				// Ready stands until the host returns it, or one step in async mode
				if (!mode_sync_ff && step) nxt_state = hbhd_pkg::HBHD_HOLD;
				else if (mode_sync_ff && !rtn_lvl_ff && step) nxt_state = hbhd_pkg::HBHD_HOLD;
			end
			hbhd_pkg::HBHD_HOLD: begin
				if (!start_lvl_ff) nxt_state = hbhd_pkg::HBHD_IDLE;
			end
			default: nxt_state = hbhd_pkg::HBHD_IDLE;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_ff <= hbhd_pkg::HBHD_IDLE;
			wait_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			wait_ff <= nxt_wait;
		end
	end
	// ****************************************
	// Ready outputs
	// ****************************************
	// In sync mode, sync ready changes only on a bus clock edge so the host sees it aligned
	logic srdy_ff, async_ready_out_ff, done_ff;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) srdy_ff <= 1'b1;
		else if (!mode_sync_ff) begin
			// Burst: low while waits are still needed
			srdy_ff <= ~(state_ff == hbhd_pkg::HBHD_WAIT);
		end else if (bclk_rise) begin
			// Falling edge marks ready in VLBus-like mode
			srdy_ff <= ~(state_ff == hbhd_pkg::HBHD_RDY);
		end
	end
	// Async ready low while waiting in async mode; stays high in sync mode; needs no bus clock
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) async_ready_out_ff <= 1'b1;
		else async_ready_out_ff <= ~(!mode_sync_ff && state_ff == hbhd_pkg::HBHD_WAIT);
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) done_ff <= 1'b0;
		else done_ff <= (state_ff != hbhd_pkg::HBHD_HOLD) && (nxt_state == hbhd_pkg::HBHD_HOLD);
	end
	assign bus.sync_ready_n = srdy_ff;
	assign bus.async_ready_out = async_ready_out_ff;
	assign cycle_done_o = done_ff;
	// ****************************************
	// Decode and event outputs
	// ****************************************
	// Combinational on purpose: hosts latch it within the address phase
	assign bus.local_device_hit_n = ~(~bus.address_enable_in
		& (bus.addr[hbhd_pkg::DEC_HI:hbhd_pkg::DEC_LO] == base_addr_i));
	// Queue path ignores address enable and bank select
	assign queue_access_o = ~bus.data_path_select_n;
	logic intr_ff, pme_ff;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			intr_ff <= 1'b1;
			pme_ff <= 1'b1;
		end else begin
			intr_ff <= ~irq_status_any_i;
			pme_ff <= ~wake_event_i;
		end
	end
	assign bus.interrupt_out_n = intr_ff;
	assign bus.power_event_n = pme_ff;
endmodule : hbhd_dev

// ===== hw/hbhd_host.sv
// Host end: bus clock divider, cycle launch, ready return
`timescale 1ns/10ps
module hbhd_host (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	hbhd_if.host bus,
	input wire logic sync_mode_i,
	input wire logic req_i,
	input wire logic read_i,
	input wire logic burst_wait_i,
	input wire logic [hbhd_pkg::ADDR_W-1:0] addr_i,
	input wire logic queue_sel_i,
	output logic busy_o,
	output logic done_o
);
	// ****************************************
	// Bus clock
	// ****************************************
	// Divided to stay under the ceiling; held low in async mode
	logic [3:0] div_ff;
	logic bclk_ff;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !sync_mode_i) begin
			div_ff <= 4'h0;
			bclk_ff <= 1'b0;
		end else if (div_ff == 4'(hbhd_pkg::LCLK_DIV - 1)) begin
			div_ff <= 4'h0;
			bclk_ff <= ~bclk_ff;
		end else div_ff <= div_ff + 4'h1;
	end
	// ****************************************
	// Cycle sequencing
	// ****************************************
	logic busy_ff, done_ff, rtn_ff, rd_ff, start_ff, seen_ff;
	logic [hbhd_pkg::ADDR_W-1:0] addr_ff;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			busy_ff <= 1'b0;
			start_ff <= 1'b0;
			rtn_ff <= 1'b1;
			rd_ff <= 1'b1;
			addr_ff <= '0;
			done_ff <= 1'b0;
			seen_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (!busy_ff && req_i) begin
				busy_ff <= 1'b1;
				start_ff <= 1'b1;
				rd_ff <= read_i;
				addr_ff <= addr_i;
				seen_ff <= 1'b0;
			end else if (busy_ff) begin
				if (sync_mode_i) begin
					// Return ready once the device signals it
					if (!bus.sync_ready_n) begin
						rtn_ff <= 1'b0;
						seen_ff <= 1'b1;
					end
				end else begin
					rtn_ff <= ~burst_wait_i;
					if (!bus.async_ready_out) seen_ff <= 1'b1;
				end
				// Sync: keep the return low until the device withdraws its ready
				if (seen_ff && (sync_mode_i ? bus.sync_ready_n : bus.async_ready_out)) begin
					busy_ff <= 1'b0;
					start_ff <= 1'b0;
					rtn_ff <= 1'b1;
					done_ff <= 1'b1;
				end
			end
		end
	end
	assign bus.bclk = bclk_ff;
	assign bus.cyc_start = start_ff;
	assign bus.ready_return_n = rtn_ff;
	assign bus.addr = addr_ff;
	assign bus.address_enable_in = ~busy_ff;
	assign bus.data_path_select_n = ~(busy_ff & queue_sel_i);
	assign bus.read_strobe_n = ~(busy_ff & rd_ff & !sync_mode_i);
	assign bus.cycle_marker_n = sync_mode_i ? ~busy_ff : ~rd_ff;
	assign bus.bus_mode_strap_n = ~sync_mode_i;
	assign busy_o = busy_ff;
	assign done_o = done_ff;
endmodule : hbhd_host

// ===== dv/hbhd_props.sv
// Concurrent checks on the pins joining the host and device ends
`timescale 1ns/10ps
module hbhd_props #(
	parameter logic [hbhd_pkg::DEC_W-1:0] BASE = hbhd_pkg::BASE_RST
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [hbhd_pkg::ADDR_W-1:0] addr,
	input wire logic address_enable_in,
	input wire logic ready_return_n,
	input wire logic bus_mode_strap_n,
	input wire logic cyc_start,
	input wire logic sync_ready_n,
	input wire logic async_ready_out,
	input wire logic local_device_hit_n,
	input wire logic interrupt_out_n,
	input wire logic power_event_n
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// ****************************************
	// Cycle steps
	// ****************************************
	sequence s_start;
		$rose(cyc_start);
	endsequence
	sequence s_answer;
		!async_ready_out || !sync_ready_n;
	endsequence
	// ****************************************
	// Properties
	// ****************************************
	// Own disable, since reset is the cause here
	property p_rst;
		@(posedge clk_i) disable iff (1'b0)
		sys_rst_i |=> sync_ready_n && async_ready_out && interrupt_out_n && power_event_n;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
	property p_hit;
		local_device_hit_n == !(!address_enable_in && addr[hbhd_pkg::DEC_HI:hbhd_pkg::DEC_LO] == BASE);
	endproperty
	a_hit: assert property (p_hit) else $error("decode hit wrong");
	property p_comb;
		$changed(local_device_hit_n) |-> $changed(addr) || $changed(address_enable_in);
	endproperty
	a_comb: assert property (p_comb) else $error("hit moved alone");
	property p_ans;
		s_start |-> ##[1:160] s_answer;
	endproperty
	a_ans: assert property (p_ans) else $error("no ready answer");
	property p_srdy_cyc;
		$fell(sync_ready_n) |-> cyc_start;
	endproperty
	a_srdy_cyc: assert property (p_srdy_cyc) else $error("sync ready outside cycle");
	property p_srdy_sync;
		$fell(sync_ready_n) && !bus_mode_strap_n |-> async_ready_out;
	endproperty
	a_srdy_sync: assert property (p_srdy_sync) else $error("async wait in sync mode");
	property p_async_ready_out;
		!async_ready_out |-> cyc_start;
	endproperty
	a_async_ready_out: assert property (p_async_ready_out) else $error("async wait outside cycle");
	property p_async_ready_out_mode;
		$fell(async_ready_out) |-> bus_mode_strap_n;
	endproperty
	a_async_ready_out_mode: assert property (p_async_ready_out_mode) else $error("async wait in sync mode");
	property p_rtn;
		$fell(sync_ready_n) && !bus_mode_strap_n |-> ##[0:12] !ready_return_n;
	endproperty
	a_rtn: assert property (p_rtn) else $error("ready not returned");
endmodule : hbhd_props

// ===== dv/tb_host_bus_handshake_decode.sv
// Testbench joining host and device ends of the handshake port
`timescale 1ns/10ps
module tb_host_bus_handshake_decode;
	localparam logic [hbhd_pkg::DEC_W-1:0] BASE = 12'h0a5c;
	logic clk_i, sys_rst_i, mode, req, rd, bw, qs, irq, wake, qa, smo, busy, done, h, s, q;
	logic [15:0] addr;
	logic [3:0] wt;
	logic [4:0] c;
	logic [31:0] r;
	logic [7:0] exq[$];
	int bad_count = 0;
	int cmp_count = 0;
	int ticks = 0;
	hbhd_if bus_if();
	hbhd_dev hbhd_dev_inst(.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(bus_if.dev),
		.base_addr_i(BASE), .wait_cycles_i(wt), .irq_status_any_i(irq), .wake_event_i(wake),
		.queue_access_o(qa), .sync_mode_o(smo), .cycle_done_o());
	hbhd_host hbhd_host_inst(.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(bus_if.host),
		.sync_mode_i(mode), .req_i(req), .read_i(rd), .burst_wait_i(bw), .addr_i(addr),
		.queue_sel_i(qs), .busy_o(busy), .done_o(done));
	hbhd_props #(.BASE(BASE)) hbhd_props_inst(.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.addr(bus_if.addr), .address_enable_in(bus_if.address_enable_in),
		.ready_return_n(bus_if.ready_return_n), .bus_mode_strap_n(bus_if.bus_mode_strap_n),
		.cyc_start(bus_if.cyc_start), .sync_ready_n(bus_if.sync_ready_n),
		.async_ready_out(bus_if.async_ready_out), .local_device_hit_n(bus_if.local_device_hit_n),
		.interrupt_out_n(bus_if.interrupt_out_n), .power_event_n(bus_if.power_event_n));
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report;
		$display("counts cmp=%0d bad=%0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report
	// Inputs move a fixed 2 ns after the edge, clear of sampling
	task automatic tick;
		@(posedge clk_i);
		#2;
	endtask : tick
	// One cycle; half hit the base so decode sees both outcomes
	task automatic run_cycle;
		int n;
		r = lfsr(r);
		addr = r[3] ? {BASE, r[7:4]} : r[31:16];
		rd = r[8];
		qs = r[9];
		bw = r[10];
		wt = r[14:11];
		exq.push_back({addr[15:4] == BASE, mode, qs, mode ? 5'h00 : (wt == 4'h0 ? 5'h02 : {1'b0, wt})});
		req = 1'b1;
		tick;
		req = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 200) begin
			tick;
			n++;
		end
		chk({7'h00, done}, 8'h01);
		tick;
	endtask : run_cycle
	// Levels are synchronised, so allow a short settling wait
	task automatic levels;
		int n;
		r = lfsr(r);
		irq = r[0];
		wake = r[1];
		n = 0;
		while ((bus_if.interrupt_out_n !== ~irq || bus_if.power_event_n !== ~wake) && n < 10) begin
			tick;
			n++;
		end
		chk({6'h00, bus_if.interrupt_out_n, bus_if.power_event_n}, {6'h00, ~irq, ~wake});
	endtask : levels
	// ****************************************
	// Clock, watchdog, monitor, stimulus
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Run is about 800 cycles; a hang stops well past that
	always @(posedge clk_i) begin
		ticks++;
		if (ticks == 8000) begin
			bad_count++;
			final_report;
		end
	end
	// Gather what one cycle showed, compare on its done pulse
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			{h, s, q, c} = 8'h00;
		end else begin
			h = h | (bus_if.cyc_start & ~bus_if.local_device_hit_n);
			s = s | (bus_if.cyc_start & ~bus_if.sync_ready_n & ~bus_if.bus_mode_strap_n);
			q = q | (bus_if.cyc_start & qa);
			c = c + {4'h0, ~bus_if.async_ready_out};
			if (done === 1'b1) begin
				chk({h, s, q, c}, exq.size() > 0 ? exq.pop_front() : 8'hff);
				{h, s, q, c} = 8'h00;
			end
		end
	end
	initial begin
		int n;
		r = 32'h0001_1a9d;
		{sys_rst_i, mode, req, rd, bw, qs, irq, wake} = 8'h80;
		addr = 16'h0000;
		wt = 4'h0;
		repeat (12) @(posedge clk_i);
		#2;
		sys_rst_i = 1'b0;
		for (int m = 0; m < 2; m++) begin
			mode = m[0];
			n = 0;
			while (smo !== mode && n < 20) begin
				tick;
				n++;
			end
			chk({7'h00, smo}, {7'h00, mode});
			for (int i = 0; i < 8; i++) begin
				run_cycle;
				if (i[0]) begin
					levels;
				end
			end
			$display("test mode %0d done", m);
		end
		// Every launched cycle must have produced its result
		chk(8'(exq.size()), 8'h00);
		final_report;
	end
endmodule : tb_host_bus_handshake_decode
